/* File: design/lpb_tick.v */
// Free-running divider that yields one-cycle enable pulses
`timescale 1ns/100ps
`default_nettype none
module lpb_tick #(
	parameter integer DIV = 1000
) (
	input wire i_mclk,
	input wire i_rst_n,
	output reg o_tick
);
	reg [31:0] cnt;

	// Count up and pulse once per DIV cycles
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			cnt <= 32'h0;
			o_tick <= 1'b0;
		end else if (cnt >= DIV - 1) begin
			cnt <= 32'h0;
			o_tick <= 1'b1;
		end else begin
			cnt <= cnt + 32'h1;
			o_tick <= 1'b0;
		end
	end
endmodule // lpb_tick
`default_nettype wire

/* File: design/lpb_timer.v */
// LED pulse/breathe timing engine with its period and count registers
`timescale 1ns/100ps
`default_nettype none
`include "lpb_map.vh"
// Operation
// - Pulse-one period: seven bits, 32 ms each
// - Period zero acts as one, 32 ms
// - Trigger bit picks press or release start of pulse-one
// - Pulse-two has own 32 ms period
// - Breathe has own 32 ms period
// - Pulse-one emits count field plus one
// - Pulse-two count plus one, five default
// - Notify bit gates alert on completion
// - Each pulse ramps up then down
// - Pulse-two repeats, finishes count, then minimum
// - Breathe ramps each half period
module lpb_timer #(
	parameter integer STEP_CYCLES = `LPB_STEP_CYCLES,
	parameter integer RAMP_STEPS = `LPB_RAMP_STEPS
) (
	// Clock and reset
	input wire i_mclk,
	input wire i_rst_n,
	// Register port
	input wire [7:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_wr,
	output reg [7:0] o_reg_rdata,
	// Behaviour control
	input wire [1:0] i_led_behaviour_select,
	input wire i_touch,
	input wire i_drive_bit,
	input wire i_actuated_by_register,
	// LED outputs
	output reg [7:0] o_duty,
	output reg o_active,
	output reg o_alert
);
	localparam ST_IDLE = 2'd0;
	localparam ST_RUN = 2'd1;
	localparam ST_FINISH = 2'd2;

	reg [7:0] first_pulse_period_and_trigger;
	reg [7:0] second_pulse_period;
	reg [7:0] breath_period;
	reg [7:0] pulse_count_and_finish_notify;
	reg [1:0] state;
	reg [1:0] beh;
	reg hold;
	reg [2:0] done_cnt;
	reg [31:0] sub_cnt;
	reg [7:0] ramp;
	reg touch_m;
	reg touch_s;
	reg drive_m;
	reg drive_s;
	reg trig_prev;
	wire tick;
	wire start_on_release_select;
	wire finish_notify;
	wire [6:0] first_pulse_period_field;
	wire [6:0] second_pulse_period_field;
	wire [6:0] breath_period_field;
	wire [2:0] first_pattern_repeats;
	wire [2:0] second_pattern_repeats;
	wire on_level;
	wire on_rise;
	wire on_fall;
	wire trig_edge;
	reg [6:0] sel_field;
	reg [6:0] per_len;

	assign start_on_release_select = first_pulse_period_and_trigger[`LPB_BIT_START_ON_RELEASE];
	assign finish_notify = pulse_count_and_finish_notify[`LPB_BIT_FINISH_NOTIFY];
	assign first_pulse_period_field = first_pulse_period_and_trigger[6:0];
	assign second_pulse_period_field = second_pulse_period[6:0];
	assign breath_period_field = breath_period[6:0];
	assign first_pattern_repeats = pulse_count_and_finish_notify[`LPB_P1_CNT_HI:`LPB_P1_CNT_LO];
	assign second_pattern_repeats = pulse_count_and_finish_notify[`LPB_P2_CNT_HI:`LPB_P2_CNT_LO];

	// 32 ms pacing tick divided into ramp sub-steps
	// RAMP_STEPS ticks per period count; one ramp step per per_len ticks
	lpb_tick #(
		.DIV(STEP_CYCLES / RAMP_STEPS)
	) u_tick (
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.o_tick(tick)
	);

	// Pin synchronisers
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			touch_m <= 1'b0;
			touch_s <= 1'b0;
			drive_m <= 1'b0;
			drive_s <= 1'b0;
		end else begin
			touch_m <= i_touch;
			touch_s <= touch_m;
			drive_m <= i_drive_bit;
			drive_s <= drive_m;
		end
	end

	assign on_level = touch_s | drive_s;
	assign on_rise = on_level & ~trig_prev;
	assign on_fall = ~on_level & trig_prev;
	assign trig_edge = start_on_release_select ? on_fall : on_rise;

	// Period field select; zero treated as one
	always @* begin
		case (beh)
			`LPB_BEH_PULSE1: sel_field = first_pulse_period_field;
			`LPB_BEH_PULSE2: sel_field = second_pulse_period_field;
			default: sel_field = breath_period_field;
		endcase
		per_len = (sel_field == 7'h0) ? 7'h1 : sel_field;
	end

	// Register writes
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			first_pulse_period_and_trigger <= `LPB_RST_P1_PERIOD;
			second_pulse_period <= `LPB_RST_P2_PERIOD;
			breath_period <= `LPB_RST_BR_PERIOD;
			pulse_count_and_finish_notify <= `LPB_RST_PULSE_CFG;
		end else if (i_reg_wr) begin
			case (i_reg_addr)
				`LPB_ADDR_P1_PERIOD: first_pulse_period_and_trigger <= i_reg_wdata;
				`LPB_ADDR_P2_PERIOD: second_pulse_period <= {1'b0, i_reg_wdata[6:0]};
				`LPB_ADDR_BR_PERIOD: breath_period <= {1'b0, i_reg_wdata[6:0]};
				`LPB_ADDR_PULSE_CFG: pulse_count_and_finish_notify <= {1'b0, i_reg_wdata[6:0]};
				default: ;
			endcase
		end
	end

	// Register read-back
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			o_reg_rdata <= 8'h00;
		end else begin
			case (i_reg_addr)
				`LPB_ADDR_P1_PERIOD: o_reg_rdata <= first_pulse_period_and_trigger;
				`LPB_ADDR_P2_PERIOD: o_reg_rdata <= second_pulse_period;
				`LPB_ADDR_BR_PERIOD: o_reg_rdata <= breath_period;
				`LPB_ADDR_PULSE_CFG: o_reg_rdata <= pulse_count_and_finish_notify;
				default: o_reg_rdata <= 8'h00;
			endcase
		end
	end

	// Behaviour sequencer; ramp up over half a period, down over the other
	always @(posedge i_mclk) begin
		if (!i_rst_n) begin
			state <= ST_IDLE;
			beh <= `LPB_BEH_DIRECT;
			hold <= 1'b0;
			done_cnt <= 3'h0;
			sub_cnt <= 32'h0;
			ramp <= 8'h00;
			trig_prev <= 1'b0;
			o_duty <= 8'h00;
			o_active <= 1'b0;
			o_alert <= 1'b0;
		end else begin
			trig_prev <= on_level;
			o_alert <= 1'b0;
			case (state)
				ST_IDLE: begin
					o_active <= 1'b0;
					o_duty <= 8'h00;
					if (i_led_behaviour_select == `LPB_BEH_DIRECT) begin
						o_duty <= on_level ? 8'hff : 8'h00;
					end else if ((i_led_behaviour_select == `LPB_BEH_PULSE1) ? trig_edge : on_rise) begin
						beh <= i_led_behaviour_select;
						hold <= (i_led_behaviour_select != `LPB_BEH_PULSE1);
						done_cnt <= 3'h0;
						sub_cnt <= 32'h0;
						ramp <= 8'h00;
						state <= ST_RUN;
					end
				end
				ST_RUN: begin
					o_active <= 1'b1;
					if (on_fall) begin
						hold <= 1'b0;
					end
					if (beh == `LPB_BEH_BREATHE && !on_level) begin
						state <= ST_FINISH;
					end else if (tick) begin
						// Ramp position scales with the selected period
						if (sub_cnt + 32'h1 >= {25'h0, per_len}) begin
							sub_cnt <= 32'h0;
							ramp <= ramp + 8'h1;
							if (ramp == 8'hff) begin
								// One full up/down pulse spans the period
								if (beh == `LPB_BEH_BREATHE || (beh == `LPB_BEH_PULSE2 && hold)) begin
									done_cnt <= 3'h0;
								end else if ((beh == `LPB_BEH_PULSE1 && done_cnt == first_pattern_repeats) ||
									(beh == `LPB_BEH_PULSE2 && done_cnt == second_pattern_repeats)) begin
									state <= ST_FINISH;
								end else begin
									done_cnt <= done_cnt + 3'h1;
								end
							end
						end else begin
							sub_cnt <= sub_cnt + 32'h1;
						end
					end
					o_duty <= ramp[7] ? {~ramp[6:0], 1'b1} : {ramp[6:0], 1'b0};
				end
				ST_FINISH: begin
					o_duty <= 8'h00;
					o_active <= 1'b0;
					o_alert <= finish_notify & i_actuated_by_register;
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
endmodule // lpb_timer
`default_nettype wire

/* File: inc/lpb_map.vh */
// Register offsets, field positions, reset values and timing counts for the LED pulse/breathe timer
`ifndef LPB_MAP_VH
`define LPB_MAP_VH
`define LPB_ADDR_P1_PERIOD 8'h84
`define LPB_ADDR_P2_PERIOD 8'h85
`define LPB_ADDR_BR_PERIOD 8'h86
`define LPB_ADDR_PULSE_CFG 8'h88
`define LPB_RST_P1_PERIOD 8'h20
`define LPB_RST_P2_PERIOD 8'h14
`define LPB_RST_BR_PERIOD 8'h5d
`define LPB_RST_PULSE_CFG 8'h24
`define LPB_BIT_START_ON_RELEASE 7
`define LPB_BIT_FINISH_NOTIFY 6
`define LPB_P2_CNT_HI 5
`define LPB_P2_CNT_LO 3
`define LPB_P1_CNT_HI 2
`define LPB_P1_CNT_LO 0
`define LPB_BEH_DIRECT 2'b00
`define LPB_BEH_PULSE1 2'b01
`define LPB_BEH_PULSE2 2'b10
`define LPB_BEH_BREATHE 2'b11
`define LPB_STEP_MS 32
`define LPB_CLK_MHZ 250
`define LPB_STEP_CYCLES (`LPB_STEP_MS * 1000 * `LPB_CLK_MHZ)
`define LPB_RAMP_STEPS 256
`endif

/* File: testbench/lpb_chk.sv */
// Port checker for the LED pulse timer
`timescale 1ns/100ps
`default_nettype none
module lpb_chk (
	input wire i_mclk,
	input wire i_rst_n,
	input wire [7:0] i_reg_addr,
	input wire [7:0] i_reg_wdata,
	input wire i_reg_wr,
	input wire [7:0] o_reg_rdata,
	input wire [1:0] i_led_behaviour_select,
	input wire i_actuated_by_register,
	input wire [7:0] o_duty,
	input wire o_active,
	input wire o_alert
);
	logic notify;
	// Mirror of the finish-notify bit
	always @(posedge i_mclk)
		if (!i_rst_n)
			notify <= 1'b0;
		else if (i_reg_wr && i_reg_addr == 8'h88)
			notify <= i_reg_wdata[6];
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);
	chk_alert_gated: assert property (o_alert |-> $past(notify) && $past(i_actuated_by_register))
		else $error("alert gate");
	chk_alert_single: assert property (o_alert |=> !o_alert)
		else $error("alert width");
	chk_alert_idle: assert property (o_alert |-> !o_active && o_duty == 8'h00)
		else $error("alert timing");
	chk_end_dark: assert property ($fell(o_active) |-> o_duty == 8'h00)
		else $error("end level");
	chk_idle_dark: assert property (!o_active && !$past(o_active) && i_led_behaviour_select != 2'b00
		&& $stable(i_led_behaviour_select) |-> o_duty == 8'h00)
		else $error("idle level");
	chk_top_bit_zero: assert property (i_reg_addr inside {8'h85, 8'h86, 8'h88} |=> !o_reg_rdata[7])
		else $error("top bit");
	chk_period_back: assert property (i_reg_wr && i_reg_addr == 8'h84 ##1 i_reg_addr == 8'h84 && !i_reg_wr
		|=> o_reg_rdata == $past(i_reg_wdata, 2))
		else $error("period readback");
	chk_count_back: assert property (i_reg_wr && i_reg_addr == 8'h88 ##1 i_reg_addr == 8'h88 && !i_reg_wr
		|=> o_reg_rdata == ($past(i_reg_wdata, 2) & 8'h7f))
		else $error("count readback");
endmodule // lpb_chk
bind lpb_timer lpb_chk u_chk (.i_mclk, .i_rst_n, .i_reg_addr, .i_reg_wdata, .i_reg_wr, .o_reg_rdata,
	.i_led_behaviour_select, .i_actuated_by_register, .o_duty, .o_active, .o_alert);
`default_nettype wire

/* File: testbench/lpb_led_model.sv */
// LED on a low-side output, counting peaks
`timescale 1ns/100ps
`default_nettype none
module lpb_led_model (
	input wire logic i_mclk,
	input wire logic [7:0] i_duty,
	output logic [7:0] o_peaks = 8'h00
);
	logic lit = 1'b0;
	// One count per arrival at full brightness
	always @(posedge i_mclk) begin
		lit <= i_duty == 8'hff;
		if (i_duty == 8'hff && !lit)
			o_peaks <= o_peaks + 8'h01;
	end
endmodule // lpb_led_model
`default_nettype wire

/* File: testbench/tb_top.sv */
// Bench for the LED pulse timer
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	logic i_mclk = 1'b0;
	logic i_rst_n = 1'b0;
	logic [7:0] i_reg_addr = 8'h00;
	logic [7:0] i_reg_wdata = 8'h00;
	logic i_reg_wr = 1'b0;
	logic [1:0] i_led_behaviour_select = 2'b01;
	logic i_touch = 1'b0;
	logic i_drive_bit = 1'b0;
	logic i_actuated_by_register = 1'b1;
	wire [7:0] o_reg_rdata;
	wire [7:0] o_duty;
	wire o_active;
	wire o_alert;
	wire [7:0] peaks;
	int fails = 0;
	int samples_checked = 0;
	int cycles = 0;
	logic seen_alert = 1'b0;
	lpb_timer #(.STEP_CYCLES(512), .RAMP_STEPS(256)) u_dut (.i_mclk, .i_rst_n, .i_reg_addr, .i_reg_wdata,
		.i_reg_wr, .o_reg_rdata, .i_led_behaviour_select, .i_touch, .i_drive_bit, .i_actuated_by_register,
		.o_duty, .o_active, .o_alert);
	lpb_led_model u_led (.i_mclk, .i_duty(o_duty), .o_peaks(peaks));
	initial forever #2 i_mclk = ~i_mclk;
	// Watchdog and alert capture
	always @(posedge i_mclk) begin
		cycles <= cycles + 1;
		if (o_alert)
			seen_alert <= 1'b1;
		if (cycles == 40000) begin
			fails++;
			summarize();
		end
	end
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: %h vs %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		i_reg_addr <= a;
		i_reg_wdata <= d;
		i_reg_wr <= 1'b1;
		@(posedge i_mclk);
		i_reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_mclk);
		i_reg_addr <= a;
		repeat (2) @(posedge i_mclk);
		#1 chk({8'h00, o_reg_rdata}, {8'h00, exp});
	endtask
	// Wait out one run, then count peaks, length in steps and alert
	task automatic run(input logic [7:0] pulses, input int steps, input logic alert);
		int n;
		logic [7:0] start;
		n = 0;
		start = peaks;
		seen_alert = 1'b0;
		while (!o_active && n < 2000) begin
			@(posedge i_mclk);
			n++;
		end
		n = 0;
		while (o_active && n < 30000) begin
			@(posedge i_mclk);
			n++;
		end
		repeat (2) @(posedge i_mclk);
		chk({8'h00, peaks - start}, {8'h00, pulses});
		chk(16'((n + 256) >> 9), 16'(steps));
		chk({15'h0, seen_alert}, {15'h0, alert});
	endtask
	task automatic t_reset_values;
		rd(8'h84, 8'h20);
		rd(8'h85, 8'h14);
		rd(8'h86, 8'h5d);
		rd(8'h88, 8'h24);
	endtask
	// All ones into addresses 8'h84 to 8'h88, unmapped 8'h87 included
	task automatic t_masks;
		for (int i = 0; i < 5; i++) begin
			wr(8'h84 + 8'(i), 8'hff);
			rd(8'h84 + 8'(i), (i == 0) ? 8'hff : (i == 3) ? 8'h00 : 8'h7f);
		end
	endtask
	// Press start, period two, three pulses, notify on
	task automatic t_press_notify;
		wr(8'h84, 8'h02);
		wr(8'h88, 8'h42);
		i_touch <= 1'b1;
		run(8'd3, 6, 1'b1);
		i_touch <= 1'b0;
		repeat (8) @(posedge i_mclk);
	endtask
	// Release start, period zero, eight pulses, notify off
	task automatic t_release_zero;
		wr(8'h84, 8'h80);
		wr(8'h88, 8'h07);
		i_drive_bit <= 1'b1;
		repeat (50) @(posedge i_mclk);
		chk({15'h0, o_active}, 16'h0000);
		i_drive_bit <= 1'b0;
		run(8'd8, 8, 1'b0);
	endtask
	// Pulse two: repeats while held, then count plus one; alert gated off
	task automatic t_pulse2;
		logic [7:0] start;
		i_led_behaviour_select <= 2'b10;
		i_actuated_by_register <= 1'b0;
		wr(8'h85, 8'h01);
		wr(8'h88, 8'h48);
		start = peaks;
		i_touch <= 1'b1;
		repeat (1160) @(posedge i_mclk);
		chk({8'h00, peaks - start}, 16'h0002);
		i_touch <= 1'b0;
		run(8'd2, 2, 1'b0);
	endtask
	// Breathe: one peak per period while held, stops on release
	task automatic t_breathe;
		logic [7:0] start;
		i_led_behaviour_select <= 2'b11;
		i_actuated_by_register <= 1'b1;
		wr(8'h86, 8'h01);
		start = peaks;
		i_touch <= 1'b1;
		repeat (1160) @(posedge i_mclk);
		chk({8'h00, peaks - start}, 16'h0002);
		i_touch <= 1'b0;
		run(8'd0, 0, 1'b1);
	endtask
	// Direct: drive level gives full on, then full off
	task automatic t_direct;
		i_led_behaviour_select <= 2'b00;
		i_drive_bit <= 1'b1;
		repeat (8) @(posedge i_mclk);
		chk({8'h00, o_duty}, 16'h00ff);
		chk({15'h0, o_active}, 16'h0000);
		i_drive_bit <= 1'b0;
		repeat (8) @(posedge i_mclk);
		chk({8'h00, o_duty}, 16'h0000);
	endtask
	task automatic summarize;
		$display("fails %0d samples_checked %0d", fails, samples_checked);
		if (fails == 0 && samples_checked > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	initial begin
		repeat (10) @(posedge i_mclk);
		i_rst_n <= 1'b1;
		t_reset_values();
		t_masks();
		t_press_notify();
		t_release_zero();
		t_pulse2();
		t_breathe();
		t_direct();
		summarize();
	end
endmodule // tb_top
`default_nettype wire
